//--- logic/scan_and_regulator_config.sv
// scan slowdown, wake rate and regulator control register bank
`timescale 1ns/100ps
`include "scan_reg_consts.svh"
// Functional notes
// - balancing slowdown inserts current-only measurements
// - idle slowdown field applies without balancing
// - sleep wake conversion 48/24/12/6 ms, reset 2
// - second regulator level follows code mapping
// - second default enable reapplied at initialisation
// - first regulator level uses same mapping
// - first default enable reapplied at initialisation
// - pre-regulator follows its enable bit
// - watchdog trip: none, off, or power cycle
// - off time zero permanent, else seconds
module scan_and_regulator_config #(
    parameter int WAKE_BASE_CYCLES = `WAKE_BASE_MS * (`CLK_HZ / 1000)
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire scan_reg_pkg::bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic balancing_active,
    input wire logic scan_loop_done,
    input wire logic cc_meas_done,
    input wire logic sleep_mode,
    input wire logic init_pulse,
    input wire logic host_watchdog_trip,
    input wire logic second_tick,
    output logic cc_only_pending,
    output logic wake_conv_start,
    output logic first_regulator_on,
    output logic second_regulator_on,
    output logic [12:0] first_regulator_mv,
    output logic [12:0] second_regulator_mv,
    output logic pre_regulator_on
);

    // ------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------

    localparam logic [19:0] WAKE_LAST = 20'(WAKE_BASE_CYCLES - 1); // last cycle of 6 ms

    scan_reg_pkg::state_t s_r; // registered state
    scan_reg_pkg::state_t s_nxt; // next state
    logic [1:0] slow_sel; // active slowdown code
    logic [1:0] wake_code; // wake rate code
    logic [3:0] units_need; // 6 ms units per conversion
    logic [1:0] act; // watchdog action code
    logic [3:0] off_time; // watchdog off duration

    // level code to millivolts; codes below 4 all give 1.8 V
    function automatic logic [12:0] level_mv(input logic [2:0] code);
        logic [12:0] mv;
        mv = `MV_1V8;
        case (code)
            `LVL_2V5: mv = `MV_2V5;
            `LVL_3V0: mv = `MV_3V0;
            `LVL_3V3: mv = `MV_3V3;
            `LVL_5V0: mv = `MV_5V0;
            default: mv = `MV_1V8;
        endcase
        return mv;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------

    // one process computes every next value
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wake_start = 1'b0;
        s_nxt.rdata = 8'h00;
        act = s_r.wdog[`ACT_HI:`ACT_LO];
        off_time = s_r.wdog[`TIME_HI:`TIME_LO];
        wake_code = s_r.scan_cfg[`WAKE_HI:`WAKE_LO];
        units_need = `WAKE_UNITS_MAX >> wake_code;
        // balancing picks its own field, otherwise the idle one
        if (balancing_active)
        begin
            slow_sel = s_r.scan_cfg[`BAL_HI:`BAL_LO];
        end
        else
        begin
            slow_sel = s_r.scan_cfg[`IDLE_HI:`IDLE_LO];
        end

        // register writes; reserved bits are masked to zero
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                `ADDR_SCAN_CFG: s_nxt.scan_cfg = bus_req.wdata & `SCAN_MASK;
                `ADDR_LEVELS: s_nxt.levels = bus_req.wdata;
                `ADDR_PRE_REG: s_nxt.pre_reg = bus_req.wdata & `PRE_REG_MASK;
                `ADDR_WDOG: s_nxt.wdog = bus_req.wdata & `WDOG_MASK;
                default: s_nxt.rdata = 8'h00; // unmapped write ignored
            endcase
        end

        // register reads; data stand in the next cycle only
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                `ADDR_SCAN_CFG: s_nxt.rdata = s_r.scan_cfg;
                `ADDR_LEVELS: s_nxt.rdata = s_r.levels;
                `ADDR_PRE_REG: s_nxt.rdata = s_r.pre_reg;
                `ADDR_WDOG: s_nxt.rdata = s_r.wdog;
                `ADDR_STATUS:
                begin
                    s_nxt.rdata[`ST_R1_ON] = s_r.first_on;
                    s_nxt.rdata[`ST_R2_ON] = s_r.second_on;
                    s_nxt.rdata[`ST_TOG_WAIT] = (s_r.tog == scan_reg_pkg::tog_wait);
                    s_nxt.rdata[`ST_CC_PEND] = (s_r.cc_left != 3'h0);
                    s_nxt.rdata[`ST_CNT_HI:`ST_CNT_LO] = s_r.off_left;
                end
                default: s_nxt.rdata = 8'h00; // unmapped reads zero
            endcase
        end

        // after each voltage and temperature loop, queue 2^code - 1
        // current-only slots; each finished slot retires one
        if (scan_loop_done)
        begin
            s_nxt.cc_left = 3'((4'h1 << slow_sel) - 4'h1);
        end
        else if (cc_meas_done && (s_r.cc_left != 3'h0))
        begin
            s_nxt.cc_left = s_r.cc_left - 3'h1;
        end

        // wake comparator conversions only run in sleep
        if (!sleep_mode)
        begin
            s_nxt.wake_cyc = 20'h00000;
            s_nxt.wake_units = 4'h0;
        end
        else if (s_r.wake_cyc == WAKE_LAST)
        begin
            s_nxt.wake_cyc = 20'h00000;
            // a conversion every units_need periods of 6 ms
            if (s_r.wake_units >= units_need - 4'h1)
            begin
                s_nxt.wake_units = 4'h0;
                s_nxt.wake_start = 1'b1;
            end
            else
            begin
                s_nxt.wake_units = s_r.wake_units + 4'h1;
            end
        end
        else
        begin
            s_nxt.wake_cyc = s_r.wake_cyc + 20'h00001;
        end

        // initialisation reapplies the stored default enables
        if (init_pulse)
        begin
            s_nxt.first_on = s_r.levels[`R1EN];
            s_nxt.second_on = s_r.levels[`R2EN];
            s_nxt.tog = scan_reg_pkg::tog_idle;
            s_nxt.off_left = 4'h0;
        end
        else
        begin
            // power-cycle countdown in whole seconds
            unique case (s_r.tog)
                scan_reg_pkg::tog_idle:
                begin
                    s_nxt.off_left = 4'h0;
                end
                scan_reg_pkg::tog_wait:
                begin
                    if (second_tick)
                    begin
                        if (s_r.off_left == 4'h1)
                        begin
                            s_nxt.first_on = 1'b1;
                            s_nxt.second_on = 1'b1;
                            s_nxt.tog = scan_reg_pkg::tog_idle;
                            s_nxt.off_left = 4'h0;
                        end
                        else
                        begin
                            s_nxt.off_left = s_r.off_left - 4'h1;
                        end
                    end
                end
            endcase
        end

        // an off or power-cycle trip overrides initialisation in the same cycle; none and reserved leave it alone
        if (host_watchdog_trip)
        begin
            case (act)
                `ACT_OFF:
                begin
                    s_nxt.first_on = 1'b0;
                    s_nxt.second_on = 1'b0;
                    s_nxt.tog = scan_reg_pkg::tog_idle;
                    s_nxt.off_left = 4'h0;
                end
                `ACT_TOGGLE:
                begin
                    s_nxt.first_on = 1'b0;
                    s_nxt.second_on = 1'b0;
                    // zero duration means stay off for good
                    if (off_time == 4'h0)
                    begin
                        s_nxt.tog = scan_reg_pkg::tog_idle;
                        s_nxt.off_left = 4'h0;
                    end
                    else
                    begin
                        s_nxt.tog = scan_reg_pkg::tog_wait;
                        s_nxt.off_left = off_time;
                    end
                end
                default: s_nxt.off_left = s_nxt.off_left;
            endcase
        end

        // level outputs decoded from the stored codes
        s_nxt.first_mv = level_mv(s_r.levels[`R1V_HI:`R1V_LO]);
        s_nxt.second_mv = level_mv(s_r.levels[`R2V_HI:`R2V_LO]);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------

    // synchronous reset to the power-on defaults
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s_r <= '0;
            s_r.scan_cfg <= `SCAN_CFG_RST;
            s_r.levels <= `LEVELS_RST;
            s_r.pre_reg <= `PRE_REG_RST;
            s_r.wdog <= `WDOG_RST;
            s_r.tog <= scan_reg_pkg::tog_idle;
            s_r.first_mv <= `MV_1V8;
            s_r.second_mv <= `MV_1V8;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    assign bus_rdata = s_r.rdata;
    assign cc_only_pending = (s_r.cc_left != 3'h0);
    assign wake_conv_start = s_r.wake_start;
    assign first_regulator_on = s_r.first_on;
    assign second_regulator_on = s_r.second_on;
    assign first_regulator_mv = s_r.first_mv;
    assign second_regulator_mv = s_r.second_mv;
    assign pre_regulator_on = s_r.pre_reg[`PRE_EN];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // watchdog trip with the off and power-cycle actions, and the last second of a wait
    sequence s_trip_off;
        host_watchdog_trip && (act == `ACT_OFF);
    endsequence
    sequence s_trip_timed;
        host_watchdog_trip && (act == `ACT_TOGGLE) && (off_time != 4'h0);
    endsequence
    sequence s_trip_perm;
        host_watchdog_trip && (act == `ACT_TOGGLE) && (off_time == 4'h0);
    endsequence
    sequence s_last_second;
        (s_r.tog == scan_reg_pkg::tog_wait) && (s_r.off_left == 4'h1) && second_tick;
    endsequence

    a_bal_slowdown: assert property (
        balancing_active && scan_loop_done && (s_r.scan_cfg[`BAL_HI:`BAL_LO] == 2'h3)
        |=> cc_only_pending && (s_r.cc_left == 3'h7))
        else $error("balancing eighth speed not queued");
    a_idle_slowdown: assert property (
        !balancing_active && scan_loop_done && (s_r.scan_cfg[`IDLE_HI:`IDLE_LO] == 2'h1)
        |=> s_r.cc_left == 3'h1)
        else $error("idle half speed not queued");
    a_wake_reset: assert property (@(posedge sys_clk) disable iff (1'b0)
        $past(srst) && !srst |-> s_r.scan_cfg[`WAKE_HI:`WAKE_LO] == `WAKE_RST_CODE)
        else $error("wake rate reset value wrong");
    a_wake_awake: assert property (
        !sleep_mode |=> !wake_conv_start)
        else $error("wake conversion outside sleep");
    a_second_level: assert property (
        s_r.levels[`R2V_HI:`R2V_LO] == `LVL_3V3 |=> second_regulator_mv == `MV_3V3)
        else $error("second level decode wrong");
    a_first_level: assert property (
        s_r.levels[`R1V_HI:`R1V_LO] < `LVL_2V5 |=> first_regulator_mv == `MV_1V8)
        else $error("first level decode wrong");
    a_second_default: assert property (
        init_pulse && !host_watchdog_trip
        |=> second_regulator_on == $past(s_r.levels[`R2EN]))
        else $error("second default enable not reapplied");
    a_first_default: assert property (
        init_pulse && !host_watchdog_trip
        |=> first_regulator_on == $past(s_r.levels[`R1EN]))
        else $error("first default enable not reapplied");
    a_pre_enable: assert property (
        bus_req.wr && (bus_req.addr == `ADDR_PRE_REG)
        |=> (pre_regulator_on == $past(bus_req.wdata[`PRE_EN])) && (s_r.pre_reg[7:2] == 6'h00))
        else $error("pre-regulator enable mismatch");
    a_trip_off: assert property (
        s_trip_off |=> !first_regulator_on && !second_regulator_on)
        else $error("watchdog off action failed");
    a_toggle_wait: assert property (
        s_trip_timed |=> !first_regulator_on && (s_r.off_left == $past(off_time)))
        else $error("timed off not started");
    a_toggle_perm: assert property (
        s_trip_perm |=> !second_regulator_on && (s_r.tog == scan_reg_pkg::tog_idle))
        else $error("permanent off wrong");
    a_toggle_back: assert property (
        s_last_second ##0 !host_watchdog_trip ##0 !init_pulse
        |=> first_regulator_on && second_regulator_on)
        else $error("regulators not restored");
    a_rsvd_action: assert property (
        host_watchdog_trip && (act == `ACT_RSVD) && !init_pulse
        && (s_r.tog == scan_reg_pkg::tog_idle)
        |=> $stable(first_regulator_on) && $stable(second_regulator_on))
        else $error("reserved action changed regulators");

endmodule

//--- logic/scan_reg_consts.svh
// constants for the scan and regulator configuration bank
`ifndef SCAN_REG_CONSTS_SVH
`define SCAN_REG_CONSTS_SVH

// register offsets
`define ADDR_SCAN_CFG 8'h00
`define ADDR_LEVELS 8'h01
`define ADDR_PRE_REG 8'h02
`define ADDR_WDOG 8'h03
`define ADDR_STATUS 8'h04

// reset values and writable masks
`define SCAN_CFG_RST 8'h02
`define LEVELS_RST 8'h00
`define PRE_REG_RST 8'h00
`define WDOG_RST 8'h00
`define SCAN_MASK 8'h3f
`define PRE_REG_MASK 8'h03
`define WDOG_MASK 8'h3f

// scan configuration fields
`define BAL_HI 5
`define BAL_LO 4
`define IDLE_HI 3
`define IDLE_LO 2
`define WAKE_HI 1
`define WAKE_LO 0
`define WAKE_RST_CODE 2'h2

// regulator configuration fields
`define R2V_HI 7
`define R2V_LO 5
`define R2EN 4
`define R1V_HI 3
`define R1V_LO 1
`define R1EN 0
`define PRE_EN 0

// level codes and their output in millivolts
`define LVL_2V5 3'h4
`define LVL_3V0 3'h5
`define LVL_3V3 3'h6
`define LVL_5V0 3'h7
`define MV_1V8 13'h708
`define MV_2V5 13'h9c4
`define MV_3V0 13'hbb8
`define MV_3V3 13'hce4
`define MV_5V0 13'h1388

// watchdog action fields and codes
`define ACT_HI 5
`define ACT_LO 4
`define TIME_HI 3
`define TIME_LO 0
`define ACT_NONE 2'h0
`define ACT_OFF 2'h1
`define ACT_TOGGLE 2'h2
`define ACT_RSVD 2'h3

// status bit positions
`define ST_R1_ON 0
`define ST_R2_ON 1
`define ST_TOG_WAIT 2
`define ST_CC_PEND 3
`define ST_CNT_HI 7
`define ST_CNT_LO 4

// timing: fastest wake conversion period and clock rate
`define WAKE_BASE_MS 6
`define CLK_HZ 100000000
`define WAKE_UNITS_MAX 4'h8

`endif

//--- logic/scan_reg_pkg.sv
// types for the scan and regulator configuration bank
package scan_reg_pkg;

    // one register bus request
    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // watchdog power-cycle sequencer
    typedef enum logic [0:0] {tog_idle, tog_wait} tog_state_t;

    // complete state of the bank
    typedef struct packed
    {
        logic [7:0] scan_cfg;
        logic [7:0] levels;
        logic [7:0] pre_reg;
        logic [7:0] wdog;
        logic [7:0] rdata;
        logic first_on;
        logic second_on;
        tog_state_t tog;
        logic [3:0] off_left;
        logic [2:0] cc_left;
        logic [19:0] wake_cyc;
        logic [3:0] wake_units;
        logic wake_start;
        logic [12:0] first_mv;
        logic [12:0] second_mv;
    } state_t;

endpackage

//--- tb/cfg_host.sv
// host model: writes and reads the bank over the plain register port
`timescale 1ns/100ps
module cfg_host
(
    input wire logic sys_clk,
    output scan_reg_pkg::bus_req_t bus_req,
    input wire logic [7:0] bus_rdata
);
    // idle bus from time zero
    initial bus_req = '0;

    // one-cycle write strobe beside address and data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 d = bus_rdata;
    endtask
endmodule

//--- tb/tb_scan_and_regulator_config.sv
// self-checking bench for the scan and regulator configuration bank
`timescale 1ns/100ps
`include "scan_reg_consts.svh"
module tb_scan_and_regulator_config;
    // ----------------
    // signals
    // ----------------
    logic sys_clk = 1'b0; // bench clock
    logic srst = 1'b1; // reset held at start
    logic [4:0] ev = '0; // init, trip, tick, loop done, meas done
    logic balancing_active = 1'b0; // balancing level
    logic sleep_mode = 1'b0; // sleep level
    scan_reg_pkg::bus_req_t bus_req; // from host model
    logic [7:0] bus_rdata;
    logic cc_only_pending;
    logic wake_conv_start;
    logic first_regulator_on;
    logic second_regulator_on;
    logic [12:0] first_regulator_mv;
    logic [12:0] second_regulator_mv;
    logic pre_regulator_on;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0; // timeout counter
    logic [31:0] seed = 32'h4bb86b0b; // xorshift state
    logic [7:0] mdl [0:3]; // model of stored contents
    logic [7:0] msk [0:3] = '{`SCAN_MASK, 8'hff, `PRE_REG_MASK, `WDOG_MASK};
    logic [7:0] d; // read data

    always #5 sys_clk = ~sys_clk;

    // ----------------
    // design and host
    // ----------------
    scan_and_regulator_config #(.WAKE_BASE_CYCLES(4)) i_dut
    (
        .sys_clk, .srst, .bus_req, .bus_rdata, .balancing_active,
        .scan_loop_done(ev[3]), .cc_meas_done(ev[4]), .sleep_mode,
        .init_pulse(ev[0]), .host_watchdog_trip(ev[1]), .second_tick(ev[2]),
        .cc_only_pending, .wake_conv_start, .first_regulator_on,
        .second_regulator_on, .first_regulator_mv, .second_regulator_mv,
        .pre_regulator_on
    );
    cfg_host i_host (.sys_clk, .bus_req, .bus_rdata);

    // ----------------
    // helpers
    // ----------------
    // xorshift step
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // level code to millivolts
    function automatic int mv_of(input int c);
        case (c)
            4: return 2500;
            5: return 3000;
            6: return 3300;
            7: return 5000;
            default: return 1800;
        endcase
    endfunction

    // compare and count
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // wait one edge, let its updates land
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    // one-cycle event pulse
    task automatic pulse(input int i);
        @(posedge sys_clk);
        ev[i] <= 1'b1;
        @(posedge sys_clk);
        ev[i] <= 1'b0;
        #1;
    endtask

    // verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            results();
        end
    end

    // ----------------
    // scenarios
    // ----------------
    initial
    begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        step();
        // reset contents, status and an unmapped place
        for (int a = 0; a < 6; a++)
        begin
            i_host.rd(8'(a), d);
            check("reset read", d, (a == 0) ? `SCAN_CFG_RST : 8'h00);
        end
        // random writes, unmapped and read-only among them
        mdl = '{`SCAN_CFG_RST, 8'h00, 8'h00, 8'h00};
        for (int k = 0; k < 16; k++)
        begin
            int a;
            seed = xs(seed);
            a = seed[2:0] % 6;
            i_host.wr(8'(a), seed[15:8]);
            if (a < 4)
                mdl[a] = seed[15:8] & msk[a];
        end
        for (int a = 0; a < 4; a++)
        begin
            i_host.rd(8'(a), d);
            check("readback", d, mdl[a]);
        end
        check("pre on", pre_regulator_on, mdl[2][0]);
        // every level code on both regulators, written while off
        for (int c = 0; c < 8; c++)
        begin
            i_host.wr(`ADDR_LEVELS, {3'(c), 1'b0, 3'(7 - c), 1'b0});
            step();
            check("first mv", first_regulator_mv, mv_of(7 - c));
            check("second mv", second_regulator_mv, mv_of(c));
        end
        // default enables applied at initialisation
        i_host.wr(`ADDR_PRE_REG, 8'h01);
        for (int e = 0; e < 4; e++)
        begin
            i_host.wr(`ADDR_LEVELS, {3'h0, e[1], 3'h0, e[0]});
            pulse(0);
            step();
            check("first on", first_regulator_on, e[0]);
            check("second on", second_regulator_on, e[1]);
        end
        check("pre on", pre_regulator_on, 1'b1);
        // inserted current-only slots per slowdown code and balancing state
        for (int s = 0; s < 8; s++)
        begin
            int n;
            n = 0;
            i_host.wr(`ADDR_SCAN_CFG, {2'h0, 2'(s), 2'(3 - s), 2'h3});
            balancing_active <= s[2];
            pulse(3);
            step();
            while (cc_only_pending === 1'b1 && n < 10)
            begin
                pulse(4);
                step();
                n++;
            end
            check("cc slots", n, s[2] ? (1 << s[1:0]) - 1 : (1 << (3 - s[1:0])) - 1);
        end
        // wake conversion period per rate code
        for (int w = 0; w < 4; w++)
        begin
            int n;
            i_host.wr(`ADDR_SCAN_CFG, {6'h00, 2'(w)});
            sleep_mode <= 1'b1;
            n = 0;
            do
            begin
                step();
                n++;
            end while (wake_conv_start !== 1'b1 && n < 100);
            n = 0;
            do
            begin
                step();
                n++;
            end while (wake_conv_start !== 1'b1 && n < 100);
            check("wake period", n, (8 >> w) * 4);
            @(posedge sys_clk);
            sleep_mode <= 1'b0;
        end
        // watchdog actions with off times 0, 1 and 3
        i_host.wr(`ADDR_LEVELS, 8'h11);
        for (int t = 0; t < 12; t++)
        begin
            int act;
            int tm;
            logic on;
            act = t % 4;
            tm = (t < 4) ? 0 : (t < 8) ? 1 : 3;
            i_host.wr(`ADDR_WDOG, 8'(act * 16 + tm));
            pulse(0);
            pulse(1);
            step();
            on = (act == 0 || act == 3);
            check("trip first", first_regulator_on, on);
            check("trip second", second_regulator_on, on);
            // status: seconds left, cc pending, waiting, second on, first on
            i_host.rd(`ADDR_STATUS, d);
            check("status", d, {4'((act == 2) ? tm : 0), 1'b0, act == 2 && tm > 0, on, on});
            for (int k = 1; k < 5; k++)
            begin
                pulse(2);
                step();
                on = (act == 0 || act == 3 || (act == 2 && tm > 0 && k >= tm));
                check("tick first", first_regulator_on, on);
                check("tick second", second_regulator_on, on);
            end
        end
        // mid-run reset brings back the power-on contents
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        step();
        check("reset on", {first_regulator_on, second_regulator_on}, 2'b00);
        i_host.rd(`ADDR_SCAN_CFG, d);
        check("reset wake", d, `SCAN_CFG_RST);
        results();
    end
endmodule
